// ---- hw/tcmo_map.svh ----
// Purpose: register offsets, field positions and reset values of the timer compare block
// Assumes: 32-bit classic Wishbone slave, word-aligned registers
// Notes:   definitions only
`ifndef TCMO_MAP_SVH
`define TCMO_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TCMO_OFF_CTRL      5'h00
`define TCMO_OFF_COUNT     5'h04
`define TCMO_OFF_COMPARE   5'h08
`define TCMO_OFF_STATUS    5'h0c
`define TCMO_OFF_PORT      5'h10

// ****************************************
// field positions
// ****************************************
`define TCMO_CTRL_WMODE_LSB  0
`define TCMO_CTRL_COM_LSB    4
`define TCMO_CTRL_FORCE_BIT  8
`define TCMO_STAT_OVF_BIT    0
`define TCMO_STAT_MATCH_BIT  1
`define TCMO_STAT_OCS_BIT    2
`define TCMO_PORT_VAL_BIT    0
`define TCMO_PORT_DIR_BIT    1
`define TCMO_PORT_PIN_BIT    2

// ****************************************
// waveform and compare mode codes and reset values
// ****************************************
`define TCMO_WM_NORMAL     2'h0
`define TCMO_WM_PHASE      2'h1
`define TCMO_WM_CTC        2'h2
`define TCMO_WM_FAST       2'h3
`define TCMO_COM_NONE      2'h0
`define TCMO_COM_TOGGLE    2'h1
`define TCMO_COM_CLEAR     2'h2
`define TCMO_COM_SET       2'h3
`define TCMO_RST_WMODE     2'h0
`define TCMO_RST_COM       2'h0
`define TCMO_RST_OCS       1'b0

`endif

// ---- hw/tcmo_pkg.sv ----
// Purpose: shared types of the timer compare block
// Assumes: codes of these types are given in tcmo_map.svh
// Notes:   none
package tcmo_pkg;
    typedef logic [1:0] tcmo_wmode_t;
    typedef logic [1:0] tcmo_com_t;
endpackage : tcmo_pkg

// ---- hw/tcmo_compare_out.sv ----
// Purpose: compare output state register and its per-mode actions
// Assumes: match_i and bottom_i are single-cycle events on timer ticks
// Notes:   state is never touched by a mode change, only by match, bottom or force
`timescale 1ns/1ps
`include "tcmo_map.svh"

module tcmo_compare_out
    import tcmo_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire tcmo_wmode_t wmode_i,
    input  wire tcmo_com_t   com_i,
    input  wire logic        up_i,
    input  wire logic        match_i,
    input  wire logic        bottom_i,
    input  wire logic        force_i,
    output logic             state_o
);

    logic ocs_r;
    logic ocs_nxt;
    logic non_pwm;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        // no mode change touches the state, only match, bottom or force
        ocs_nxt = ocs_r;
        non_pwm = (wmode_i == `TCMO_WM_NORMAL) || (wmode_i == `TCMO_WM_CTC);
        if (non_pwm) begin
            if (match_i || force_i) begin
                case (com_i)
                    `TCMO_COM_TOGGLE: ocs_nxt = ~ocs_r;
                    `TCMO_COM_CLEAR:  ocs_nxt = 1'b0;
                    `TCMO_COM_SET:    ocs_nxt = 1'b1;
                    default:          ocs_nxt = ocs_r;
                endcase
            end
        end else if (com_i[1]) begin
            // com 2 non-inverted, com 3 inverted; com 1 reserved in pwm, no action
            if (wmode_i == `TCMO_WM_FAST) begin
                if (match_i) begin
                    ocs_nxt = com_i[0];
                end else if (bottom_i) begin
                    ocs_nxt = ~com_i[0];
                end
            end else if (match_i) begin
                ocs_nxt = up_i ? com_i[0] : ~com_i[0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ocs_r <= `TCMO_RST_OCS;
        end else begin
            ocs_r <= ocs_nxt;
        end
    end

    assign state_o = ocs_r;

    a_com_zero_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (match_i && com_i == `TCMO_COM_NONE && !force_i) |=> $stable(ocs_r))
        else $error("compare state moved with compare mode zero");

    a_force_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        (force_i && !wmode_i[0] && com_i == `TCMO_COM_TOGGLE) |=> (ocs_r != $past(ocs_r)))
        else $error("force strobe did not toggle compare state");

    a_mode_switch_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        (!match_i && !bottom_i && !force_i) |=> $stable(ocs_r))
        else $error("compare state changed without an event");

endmodule : tcmo_compare_out

// ---- hw/tcmo_timer.sv ----
// Purpose: 8-bit timer with compare output unit, normal, clear-on-match and pwm counting
// Assumes: timer_tick_i is a one-cycle enable from an outside prescaler
// Notes:   registers over classic Wishbone, one cycle to ack
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "tcmo_map.svh"

// Function
// - nonzero compare mode makes compare state replace port value on the pin
// - pin direction always follows the direction bit, override or not
// - pin override ignores which waveform mode is selected
// - compare state is its own register, settable before pin is output
// - compare state updates on actions regardless of the pin level
// - compare mode zero leaves compare state unchanged at a match
// - new compare mode acts from the first match after the write
// - force strobe in non-pwm modes applies the compare action at once
// - counting depends on waveform mode only, never on compare mode
// - non-pwm set/clear/toggle on match; pwm chooses inverted or not
// - mode zero always counts up, no clear on match, wraps to zero
// - overflow flag sets as counter becomes zero; counting never clears it
// - overflow flag clears when the overflow interrupt is serviced
// - software may write the counter at any time in normal mode
// - matches are still detected in normal mode
// - mode two clears the counter on match, compare value is top
// - compare state kept across waveform mode changes
module tcmo_timer
    import tcmo_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        timer_tick_i,
    input  wire logic        ovf_service_i,
    input  wire logic        match_service_i,
    output logic             overflow_flag_o,
    output logic             match_flag_o,
    input  wire logic        pin_i,
    output logic             pin_o,
    output logic             pin_oe_o
);

    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    // ****************************************
    // state
    // ****************************************
    tcmo_wmode_t      waveform_mode_r;
    tcmo_wmode_t      waveform_mode_nxt;
    tcmo_com_t        compare_output_mode_r;
    tcmo_com_t        compare_output_mode_nxt;
    logic [CNT_W-1:0] counter_value_r;
    logic [CNT_W-1:0] counter_value_nxt;
    logic [CNT_W-1:0] compare_value_r;
    logic [CNT_W-1:0] compare_value_nxt;
    logic             up_r;
    logic             up_nxt;
    logic             overflow_flag_r;
    logic             overflow_flag_nxt;
    logic             match_flag_r;
    logic             match_flag_nxt;
    logic             port_val_r;
    logic             port_val_nxt;
    logic             pin_dir_r;
    logic             pin_dir_nxt;
    logic             ack_r;
    logic             ack_nxt;
    logic [31:0]      dat_r;
    logic [31:0]      dat_nxt;

    // ****************************************
    // decode and events
    // ****************************************
    logic             req;
    logic             wr;
    logic             wr_ctrl;
    logic             wr_count;
    logic             wr_compare;
    logic             wr_status;
    logic             wr_port;
    logic             force_strobe;
    logic             match;
    logic             bottom;
    logic             ovf_set;
    logic             compare_output_state;

    always_comb begin
        req          = wb_cyc_i && wb_stb_i;
        // a write lands on the edge where ack is seen high
        wr           = req && wb_we_i && ack_r;
        wr_ctrl      = wr && wb_sel_i[0] && ({wb_adr_i[4:2], 2'b00} == `TCMO_OFF_CTRL);
        wr_count     = wr && wb_sel_i[0] && ({wb_adr_i[4:2], 2'b00} == `TCMO_OFF_COUNT);
        wr_compare   = wr && wb_sel_i[0] && ({wb_adr_i[4:2], 2'b00} == `TCMO_OFF_COMPARE);
        wr_status    = wr && wb_sel_i[0] && ({wb_adr_i[4:2], 2'b00} == `TCMO_OFF_STATUS);
        wr_port      = wr && wb_sel_i[0] && ({wb_adr_i[4:2], 2'b00} == `TCMO_OFF_PORT);
        force_strobe = wr && wb_sel_i[1] && ({wb_adr_i[4:2], 2'b00} == `TCMO_OFF_CTRL)
                       && wb_dat_i[`TCMO_CTRL_FORCE_BIT] && !waveform_mode_r[0];
        // a counter write blocks the compare in that cycle so it cannot glitch the output
        match        = timer_tick_i && !wr_count && (counter_value_r == compare_value_r);
        bottom       = timer_tick_i && !wr_count && (waveform_mode_r == `TCMO_WM_FAST)
                       && (counter_value_r == CNT_MAX);
    end

    // ****************************************
    // counter
    // ****************************************
    always_comb begin
        counter_value_nxt = counter_value_r;
        up_nxt            = up_r;
        ovf_set           = 1'b0;
        if (wr_count) begin
            counter_value_nxt = wb_dat_i[CNT_W-1:0];
        end else if (timer_tick_i) begin
            case (waveform_mode_r)
                `TCMO_WM_NORMAL: begin
                    counter_value_nxt = counter_value_r + CNT_ONE;
                    ovf_set           = (counter_value_r == CNT_MAX);
                end
                `TCMO_WM_CTC: begin
                    if (match) begin
                        counter_value_nxt = CNT_ZERO;
                    end else begin
                        counter_value_nxt = counter_value_r + CNT_ONE;
                        ovf_set           = (counter_value_r == CNT_MAX);
                    end
                end
                `TCMO_WM_FAST: begin
                    counter_value_nxt = counter_value_r + CNT_ONE;
                    ovf_set           = (counter_value_r == CNT_MAX);
                end
                `TCMO_WM_PHASE: begin
                    if (up_r) begin
                        if (counter_value_r == CNT_MAX) begin
                            counter_value_nxt = counter_value_r - CNT_ONE;
                            up_nxt            = 1'b0;
                        end else begin
                            counter_value_nxt = counter_value_r + CNT_ONE;
                        end
                    end else begin
                        if (counter_value_r == CNT_ZERO) begin
                            counter_value_nxt = CNT_ONE;
                            up_nxt            = 1'b1;
                        end else begin
                            counter_value_nxt = counter_value_r - CNT_ONE;
                            ovf_set           = (counter_value_r == CNT_ONE);
                        end
                    end
                end
                default: begin
                    counter_value_nxt = counter_value_r;
                end
            endcase
        end
        // leaving the dual-slope mode restarts upward
        if (waveform_mode_r != `TCMO_WM_PHASE) begin
            up_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_value_r <= '0;
            up_r            <= 1'b1;
        end else begin
            counter_value_r <= counter_value_nxt;
            up_r            <= up_nxt;
        end
    end

    // ****************************************
    // registers and flags
    // ****************************************
    always_comb begin
        waveform_mode_nxt       = waveform_mode_r;
        compare_output_mode_nxt = compare_output_mode_r;
        compare_value_nxt       = compare_value_r;
        port_val_nxt            = port_val_r;
        pin_dir_nxt             = pin_dir_r;
        overflow_flag_nxt       = overflow_flag_r;
        match_flag_nxt          = match_flag_r;
        if (wr_ctrl) begin
            waveform_mode_nxt       = wb_dat_i[`TCMO_CTRL_WMODE_LSB +: 2];
            // not buffered: the new mode acts at the next match
            compare_output_mode_nxt = wb_dat_i[`TCMO_CTRL_COM_LSB +: 2];
        end
        if (wr_compare) begin
            compare_value_nxt = wb_dat_i[CNT_W-1:0];
        end
        if (wr_port) begin
            port_val_nxt = wb_dat_i[`TCMO_PORT_VAL_BIT];
            pin_dir_nxt  = wb_dat_i[`TCMO_PORT_DIR_BIT];
        end
        // clears first, so a same-cycle set wins
        if (ovf_service_i || (wr_status && wb_dat_i[`TCMO_STAT_OVF_BIT])) begin
            overflow_flag_nxt = 1'b0;
        end
        if (match_service_i || (wr_status && wb_dat_i[`TCMO_STAT_MATCH_BIT])) begin
            match_flag_nxt = 1'b0;
        end
        if (ovf_set) begin
            overflow_flag_nxt = 1'b1;
        end
        if (match) begin
            match_flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            waveform_mode_r       <= `TCMO_RST_WMODE;
            compare_output_mode_r <= `TCMO_RST_COM;
            compare_value_r       <= '0;
            port_val_r            <= 1'b0;
            pin_dir_r             <= 1'b0;
            overflow_flag_r       <= 1'b0;
            match_flag_r          <= 1'b0;
        end else begin
            waveform_mode_r       <= waveform_mode_nxt;
            compare_output_mode_r <= compare_output_mode_nxt;
            compare_value_r       <= compare_value_nxt;
            port_val_r            <= port_val_nxt;
            pin_dir_r             <= pin_dir_nxt;
            overflow_flag_r       <= overflow_flag_nxt;
            match_flag_r          <= match_flag_nxt;
        end
    end

    // ****************************************
    // bus answer
    // ****************************************
    always_comb begin
        ack_nxt = req && !ack_r;
        dat_nxt = dat_r;
        if (req && !ack_r) begin
            dat_nxt = '0;
            case ({wb_adr_i[4:2], 2'b00})
                `TCMO_OFF_CTRL: begin
                    dat_nxt[`TCMO_CTRL_WMODE_LSB +: 2] = waveform_mode_r;
                    dat_nxt[`TCMO_CTRL_COM_LSB +: 2]   = compare_output_mode_r;
                end
                `TCMO_OFF_COUNT:   dat_nxt[CNT_W-1:0] = counter_value_r;
                `TCMO_OFF_COMPARE: dat_nxt[CNT_W-1:0] = compare_value_r;
                `TCMO_OFF_STATUS: begin
                    dat_nxt[`TCMO_STAT_OVF_BIT]   = overflow_flag_r;
                    dat_nxt[`TCMO_STAT_MATCH_BIT] = match_flag_r;
                    dat_nxt[`TCMO_STAT_OCS_BIT]   = compare_output_state;
                end
                `TCMO_OFF_PORT: begin
                    dat_nxt[`TCMO_PORT_VAL_BIT] = port_val_r;
                    dat_nxt[`TCMO_PORT_DIR_BIT] = pin_dir_r;
                    dat_nxt[`TCMO_PORT_PIN_BIT] = pin_i;
                end
                default: dat_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // ****************************************
    // compare output unit and pin
    // ****************************************
    tcmo_compare_out u_cmp_out (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wmode_i  (waveform_mode_r),
        .com_i    (compare_output_mode_r),
        .up_i     (up_r),
        .match_i  (match),
        .bottom_i (bottom),
        .force_i  (force_strobe),
        .state_o  (compare_output_state)
    );

    always_comb begin
        // override chosen by compare mode alone, never by waveform mode
        pin_o    = (compare_output_mode_r != `TCMO_COM_NONE) ? compare_output_state : port_val_r;
        pin_oe_o = pin_dir_r;
    end

    assign wb_ack_o        = ack_r;
    assign wb_dat_o        = dat_r;
    assign overflow_flag_o = overflow_flag_r;
    assign match_flag_o    = match_flag_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_pin_override: assert property (
        (compare_output_mode_r != `TCMO_COM_NONE) |-> (pin_o == compare_output_state))
        else $error("pin not overridden by compare state");

    a_pin_direction: assert property (
        wr_port |=> (pin_oe_o == $past(wb_dat_i[`TCMO_PORT_DIR_BIT])))
        else $error("pin enable does not follow direction bit");

    a_normal_wrap: assert property (
        (timer_tick_i && !wr_count && waveform_mode_r == `TCMO_WM_NORMAL && counter_value_r == CNT_MAX)
        |=> (counter_value_r == CNT_ZERO) && overflow_flag_r)
        else $error("normal mode did not wrap with overflow");

    a_ctc_clear: assert property (
        (match && waveform_mode_r == `TCMO_WM_CTC) |=> (counter_value_r == CNT_ZERO))
        else $error("clear-on-match mode did not clear counter");

    a_tick_only: assert property (
        (!timer_tick_i && !wr_count) |=> $stable(counter_value_r))
        else $error("counter moved without a tick");

    a_ovf_service: assert property (
        (ovf_service_i && !ovf_set) |=> !overflow_flag_r)
        else $error("overflow flag not cleared by service");

    a_ovf_sticky: assert property (
        (overflow_flag_r && !ovf_service_i && !wr_status) |=> overflow_flag_r)
        else $error("overflow flag cleared by counting");

    a_bus_ack: assert property (
        (req && !ack_r) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not a single cycle after one wait");

endmodule : tcmo_timer

// ---- tb/tcmo_pin_model.sv ----
// Purpose: far-side model of the compare output pin and its board load
// Assumes: the board holds a weak pull-up on the pin
// Notes:   an outside driver may drive the pin only while the block does not
`timescale 1ns/1ps

module tcmo_pin_model (
    input  wire logic drive_val_i,
    input  wire logic drive_en_i,
    input  wire logic ext_en_i,
    input  wire logic ext_val_i,
    output logic      pin_level_o
);
    // a released pin floats to the pull-up, it never keeps the last value
    always_comb begin
        if (drive_en_i) begin
            pin_level_o = drive_val_i;
        end else if (ext_en_i) begin
            pin_level_o = ext_val_i;
        end else begin
            pin_level_o = 1'b1;
        end
    end
endmodule : tcmo_pin_model

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench of the timer compare output block
// Assumes: one-cycle Wishbone ack, register map of tcmo_map.svh
// Notes:   prescaler is replaced by hand-made tick pulses
`timescale 1ns/1ps
`include "tcmo_map.svh"

module tb_top
    import tcmo_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0, osvc = 1'b0, msvc = 1'b0;
    logic        ext_en = 1'b0, ext_val = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_r, q;
    logic        ack, ovf, mflag, pin_lvl, pin_o, pin_oe;
    int          mismatches = 0;
    int          samples_checked = 0;

    always #2 clk_i = ~clk_i;

    tcmo_timer #(.CNT_W(8)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .timer_tick_i(tick), .ovf_service_i(osvc), .match_service_i(msvc), .overflow_flag_o(ovf),
        .match_flag_o(mflag), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe));

    tcmo_pin_model u_pin (.drive_val_i(pin_o), .drive_en_i(pin_oe), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .pin_level_o(pin_lvl));

    // *****
    // shared tasks
    // *****
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk

    // classic cycle: hold everything until ack is sampled high, then release for one idle cycle
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d; sel <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) chk(32'h1, 32'h0, "bus ack timeout");
        q = dat_r;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0);
        chk(q, e, m);
    endtask : rdc

    task automatic ctrl(input logic [1:0] wm, input logic [1:0] c, input logic f);
        bus(1'b1, `TCMO_OFF_CTRL, {23'h0, f, 2'h0, c, 2'h0, wm});
    endtask : ctrl

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_i);
            tick <= 1'b1;
            @(posedge clk_i);
            tick <= 1'b0;
        end
        @(posedge clk_i);
    endtask : ticks

    task automatic svc(input logic ov);
        @(posedge clk_i);
        if (ov) osvc <= 1'b1; else msvc <= 1'b1;
        @(posedge clk_i);
        osvc <= 1'b0; msvc <= 1'b0;
        @(posedge clk_i);
    endtask : svc

    // *****
    // scenarios
    // *****
    task automatic t_reset;
        // the released pin reads back its pull-up in bit 2 of the port word
        for (int i = 0; i < 5; i++) rdc(5'(i * 4), (i == 4) ? 32'h4 : 32'h0, "reset value");
        bus(1'b1, 5'h14, 32'hffffffff);
        rdc(5'h14, 32'h0, "unmapped read");
        chk({30'h0, pin_oe, pin_o}, 32'h0, "pin after reset");
    endtask : t_reset

    task automatic t_normal;
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_NONE, 1'b0);
        bus(1'b1, `TCMO_OFF_COUNT, 32'hfe);
        ticks(1);
        chk({31'h0, ovf}, 32'h0, "early overflow");
        ticks(1);
        rdc(`TCMO_OFF_COUNT, 32'h0, "wrap to zero");
        chk({31'h0, ovf}, 32'h1, "overflow flag");
        repeat (6) @(posedge clk_i);
        rdc(`TCMO_OFF_COUNT, 32'h0, "count without tick");
        chk({31'h0, ovf}, 32'h1, "flag kept");
        svc(1'b1);
        chk({31'h0, ovf}, 32'h0, "overflow serviced");
        bus(1'b1, `TCMO_OFF_COMPARE, 32'h2);
        ticks(3);
        chk({31'h0, mflag}, 32'h1, "normal mode match");
        rdc(`TCMO_OFF_COUNT, 32'h3, "no clear on match");
        svc(1'b0);
        chk({31'h0, mflag}, 32'h0, "match serviced");
    endtask : t_normal

    task automatic t_pin;
        bus(1'b1, `TCMO_OFF_PORT, 32'h1);
        chk({30'h0, pin_oe, pin_o}, 32'h1, "port drives pin value");
        rdc(`TCMO_OFF_PORT, 32'h5, "released pin pulled up");
        // the force acts on the compare mode already held, so the mode goes in first
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_SET, 1'b0);
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_SET, 1'b1);
        rdc(`TCMO_OFF_STATUS, 32'h4, "forced set");
        chk({31'h0, pin_oe}, 32'h0, "state before output");
        bus(1'b1, `TCMO_OFF_PORT, 32'h2);
        chk({30'h0, pin_oe, pin_o}, 32'h3, "override to state");
        rdc(`TCMO_OFF_PORT, 32'h6, "state on pin");
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_CLEAR, 1'b0);
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_CLEAR, 1'b1);
        chk({30'h0, pin_oe, pin_o}, 32'h2, "forced clear");
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_TOGGLE, 1'b0);
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_TOGGLE, 1'b1);
        chk({31'h0, pin_o}, 32'h1, "forced toggle");
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_TOGGLE, 1'b1);
        chk({31'h0, pin_o}, 32'h0, "forced toggle back");
        bus(1'b1, `TCMO_OFF_PORT, 32'h3);
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_NONE, 1'b0);
        chk({31'h0, pin_o}, 32'h1, "no override at mode zero");
        ctrl(`TCMO_WM_FAST, `TCMO_COM_CLEAR, 1'b0);
        chk({31'h0, pin_o}, 32'h0, "override in pwm mode");
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_NONE, 1'b0);
    endtask : t_pin

    task automatic t_ctc;
        ctrl(`TCMO_WM_CTC, `TCMO_COM_TOGGLE, 1'b0);
        rdc(`TCMO_OFF_STATUS, 32'h0, "mode write alone");
        bus(1'b1, `TCMO_OFF_COMPARE, 32'h3);
        bus(1'b1, `TCMO_OFF_COUNT, 32'h0);
        ticks(3);
        rdc(`TCMO_OFF_COUNT, 32'h3, "count to top");
        ticks(1);
        rdc(`TCMO_OFF_COUNT, 32'h0, "clear on match");
        rdc(`TCMO_OFF_STATUS, 32'h6, "toggle at match");
        svc(1'b0);
        ctrl(`TCMO_WM_CTC, `TCMO_COM_NONE, 1'b0);
        ticks(4);
        rdc(`TCMO_OFF_COUNT, 32'h0, "same sequence any mode");
        rdc(`TCMO_OFF_STATUS, 32'h6, "no action at mode zero");
        svc(1'b0);
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_NONE, 1'b0);
        bus(1'b1, `TCMO_OFF_PORT, 32'h0);
        ext_en <= 1'b1;
        rdc(`TCMO_OFF_STATUS, 32'h4, "state kept over mode change");
        rdc(`TCMO_OFF_PORT, 32'h0, "outside low on pin");
        ext_en <= 1'b0;
    endtask : t_ctc

    // pwm actions watched on pin_o, which shows the compare state while the compare mode is nonzero
    task automatic t_pwm;
        bus(1'b1, `TCMO_OFF_COMPARE, 32'h1);
        bus(1'b1, `TCMO_OFF_COUNT, 32'h0);
        ctrl(`TCMO_WM_FAST, `TCMO_COM_CLEAR, 1'b0);
        ticks(2);
        chk({31'h0, pin_o}, 32'h0, "fast pwm clear at match");
        bus(1'b1, `TCMO_OFF_COUNT, 32'hff);
        ticks(1);
        chk({31'h0, pin_o}, 32'h1, "fast pwm set at wrap");
        ctrl(`TCMO_WM_PHASE, `TCMO_COM_CLEAR, 1'b0);
        bus(1'b1, `TCMO_OFF_COUNT, 32'h1);
        ticks(1);
        chk({31'h0, pin_o}, 32'h0, "phase pwm clear on up match");
        bus(1'b1, `TCMO_OFF_COUNT, 32'hff);
        ticks(1);
        rdc(`TCMO_OFF_COUNT, 32'hfe, "phase pwm turns at top");
        bus(1'b1, `TCMO_OFF_COUNT, 32'h1);
        ticks(1);
        chk({31'h0, pin_o}, 32'h1, "phase pwm set on down match");
        ctrl(`TCMO_WM_NORMAL, `TCMO_COM_NONE, 1'b0);
    endtask : t_pwm

    // *****
    // main sequence and watchdog
    // *****
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_normal();
        t_pin();
        t_ctc();
        t_pwm();
        finish_test();
    end

    // the whole run takes well under 2000 cycles
    initial begin
        #40000;
        mismatches++;
        finish_test();
    end
endmodule : tb_top
